// ==== hw/ext_mem_port_cfg.svh ====
// Purpose: constants for the external memory interface
// Assumes: 16-bit data space, 8-bit bus
// Notes: address map, sector step, wait codes and buffer sizes are named here
`ifndef EXT_MEM_PORT_CFG_SVH
`define EXT_MEM_PORT_CFG_SVH
`define XM_INT_TOP 16'h025f
`define XM_EXT_BASE 16'h0260
`define XM_SECTOR_STEP_SHIFT 13
`define XM_WAIT_NONE 2'h0
`define XM_WAIT_ONE 2'h1
`define XM_WAIT_TWO 2'h2
`define XM_WAIT_TWO_ADDR 2'h3
`define XM_FIFO_WIDTH 25
`define XM_FIFO_DEPTH 16
`define XM_FIFO_AW 4
`endif

// ==== hw/ext_mem_port_pkg.sv ====
// Purpose: shared types for the external memory interface
// Assumes: nothing beyond the constants header
// Notes: types only
package ext_mem_port_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_DATA,
      ST_WAIT,
      ST_TRAIL,
      ST_HOLD
   } ext_mem_port_state_t;
endpackage : ext_mem_port_pkg

// ==== hw/ext_mem_port_fifo.sv ====
// Purpose: request buffer between the core and the bus sequencer
// Assumes: single clock, synchronous active-high reset
// Notes: width and depth shape the storage
`timescale 1ns/100ps
module ext_mem_port_fifo #(
   parameter int WIDTH = 25,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = cnt_q < (AW+1)'(DEPTH);
   assign out_valid = cnt_q != '0;
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule : ext_mem_port_fifo

// ==== hw/ext_mem_port_pin_sync.sv ====
// Purpose: two-stage synchroniser for pin inputs
// Assumes: pins are asynchronous to clk
// Notes: first stage feeds only the second
`timescale 1ns/100ps
module ext_mem_port_pin_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   assign sync_out = sync_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
endmodule : ext_mem_port_pin_sync

// ==== hw/external_memory_interface.sv ====
// Purpose: external parallel memory interface on a muxed address/data bus
// Assumes: core accesses arrive as valid/ready requests on clk
// Notes: pins are split into input, output and output enable
// Summary of operation
// - low address and data share one byte bus; upper address has maskable width
// - while enabled the interface owns the bus pins, ignoring port direction, except upper address pins released by the mask
// - each access is classified internal or external by its address
// - low address is valid on the shared bus when the latch strobe falls
// - latch strobe stays low through the data transfer phase
// - internal accesses may show bus activity but never pulse read or write
// - when disabled the pins follow port data and direction settings, except the write strobe, which is held high
// - when disabled addresses above internal memory decode as internal, never external
// - four wait settings, one of them with no wait
// - two sectors each with its own wait setting
// - bus keeper holds last driven level when the bus is released
// - pull-up on each shared line is its port output bit ORed with the keeper level on released lines while the keeper is enabled
// - trailing latch pulse only when the next access is also data memory
// - enable bit activates all bus functions, clearing restores ports
// - wait codes 00 none, 01 one, 10 two, 11 two plus address cycle
// - sector limit zero gives one upper sector; else boundary in 0x2000 steps
// - high mask releases upper address pins downward from the top bit
`timescale 1ns/100ps
`include "ext_mem_port_cfg.svh"
module external_memory_interface
   import ext_mem_port_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ext_bus_enable,
   input wire logic [1:0] sector_wait_code_lo,
   input wire logic [1:0] sector_wait_code_hi,
   input wire logic [2:0] sector_limit_field,
   input wire logic [2:0] upper_addr_mask_field,
   input wire logic bus_keeper_enable,
   input wire logic [7:0] port_a_out,
   input wire logic [7:0] port_a_dir,
   input wire logic [7:0] port_c_out,
   input wire logic [7:0] port_c_dir,
   input wire logic [1:0] port_e_out,
   input wire logic [1:0] port_e_dir,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [15:0] req_addr,
   input wire logic [7:0] req_wdata,
   input wire logic next_is_data,
   output logic resp_valid,
   output logic [7:0] resp_rdata,
   output logic resp_external,
   input wire logic [7:0] muxed_addr_data_bus_in,
   output logic [7:0] muxed_addr_data_bus_out,
   output logic [7:0] muxed_addr_data_bus_oe,
   output logic [7:0] muxed_addr_data_bus_pullup,
   output logic [7:0] upper_addr_bus_out,
   output logic [7:0] upper_addr_bus_oe,
   output logic addr_latch_out,
   output logic addr_latch_oe,
   output logic rd_n_out,
   output logic wr_n_out,
   output logic strobe_oe
);
   logic [7:0] bus_sync;
   logic f_valid;
   logic f_ready;
   logic [24:0] f_data;
   logic f_write;
   logic [15:0] f_addr;
   logic [7:0] f_wdata;
   logic f_next;
   logic is_ext;
   logic upper_sector;
   logic [1:0] sel_code;
   logic [15:0] limit_addr;
   logic [7:0] upper_keep;

   ext_mem_port_state_t state_q;
   logic [1:0] wait_q;
   logic [1:0] code_q;
   logic ext_q;
   logic wr_q;
   logic next_q;
   logic [15:0] addr_q;
   logic [7:0] wdata_q;
   logic [7:0] keep_q;
   logic [7:0] ad_out_q;
   logic [7:0] ad_oe_q;
   logic [7:0] ad_pu_q;
   logic [7:0] up_out_q;
   logic [7:0] up_oe_q;
   logic ale_q;
   logic ale_oe_q;
   logic rd_n_q;
   logic wr_n_q;
   logic strobe_oe_q;
   logic trail_q;
   logic resp_valid_q;
   logic [7:0] resp_rdata_q;
   logic resp_ext_q;

   ext_mem_port_pin_sync #(.WIDTH(8)) u_sync (
      .clk(clk),
      .rst(rst),
      .async_in(muxed_addr_data_bus_in),
      .sync_out(bus_sync)
   );

   ext_mem_port_fifo #(.WIDTH(`XM_FIFO_WIDTH), .DEPTH(`XM_FIFO_DEPTH), .AW(`XM_FIFO_AW)) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(req_valid),
      .in_ready(req_ready),
      .in_data({req_write, req_addr, req_wdata}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );

   assign f_write = f_data[24];
   assign f_addr = f_data[23:8];
   assign f_wdata = f_data[7:0];
   assign f_next = next_is_data;
   assign f_ready = (state_q == ST_IDLE);

   // internal/external decode; all accesses internal when disabled
   assign is_ext = ext_bus_enable && (f_addr > `XM_INT_TOP);
   // sector boundary in 8 KB steps
   assign limit_addr = 16'(sector_limit_field) << `XM_SECTOR_STEP_SHIFT;
   assign upper_sector = (sector_limit_field == 3'h0) || (f_addr >= limit_addr);
   assign sel_code = upper_sector ? sector_wait_code_hi : sector_wait_code_lo;
   // upper address bits kept by the mask, released from the top down
   assign upper_keep = 8'hff >> upper_addr_mask_field;

   assign muxed_addr_data_bus_out = ad_out_q;
   assign muxed_addr_data_bus_oe = ad_oe_q;
   assign muxed_addr_data_bus_pullup = ad_pu_q;
   assign upper_addr_bus_out = up_out_q;
   assign upper_addr_bus_oe = up_oe_q;
   assign addr_latch_out = ale_q;
   assign addr_latch_oe = ale_oe_q;
   assign rd_n_out = rd_n_q;
   assign wr_n_out = wr_n_q;
   assign strobe_oe = strobe_oe_q;
   assign resp_valid = resp_valid_q;
   assign resp_rdata = resp_rdata_q;
   assign resp_external = resp_ext_q;

   // access sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
         wait_q <= `XM_WAIT_NONE;
         code_q <= `XM_WAIT_NONE;
         ext_q <= 1'b0;
         wr_q <= 1'b0;
         next_q <= 1'b0;
         addr_q <= 16'h0000;
         wdata_q <= 8'h00;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (f_valid) begin
                  ext_q <= is_ext;
                  wr_q <= f_write;
                  addr_q <= f_addr;
                  wdata_q <= f_wdata;
                  next_q <= f_next;
                  code_q <= sel_code;
                  state_q <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               state_q <= ST_DATA;
               wait_q <= (code_q == `XM_WAIT_NONE) ? `XM_WAIT_NONE :
                         (code_q == `XM_WAIT_ONE) ? `XM_WAIT_ONE : `XM_WAIT_TWO;
            end
            ST_DATA: begin
               if (ext_q && wait_q != `XM_WAIT_NONE) begin
                  wait_q <= wait_q - 2'h1;
               end else begin
                  state_q <= ST_TRAIL;
               end
            end
            ST_TRAIL: begin
               // extra cycle before driving a new address
               state_q <= (ext_q && code_q == `XM_WAIT_TWO_ADDR) ? ST_HOLD : ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // latch strobe: high in address cycle, low through data, trailing pulse
   always_ff @(posedge clk) begin
      if (rst) begin
         ale_q <= 1'b0;
      end else if (!ext_bus_enable) begin
         ale_q <= port_e_out[1];
      end else begin
         case (state_q)
            ST_IDLE: ale_q <= f_valid;
            ST_ADDR: ale_q <= 1'b0;
            ST_DATA: ale_q <= (wait_q == `XM_WAIT_NONE || !ext_q) && next_q;
            default: ale_q <= 1'b0;
         endcase
      end
   end

   // read and write strobes
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_n_q <= 1'b1;
         wr_n_q <= 1'b1;
      end else if (!ext_bus_enable) begin
         rd_n_q <= port_e_out[0];
         wr_n_q <= 1'b1;
      end else begin
         // active low, only for external accesses in the data phase
         rd_n_q <= !(state_q == ST_ADDR && ext_q && !wr_q) &&
                   !(state_q == ST_DATA && ext_q && !wr_q && wait_q != `XM_WAIT_NONE);
         wr_n_q <= !(state_q == ST_ADDR && ext_q && wr_q) &&
                   !(state_q == ST_DATA && ext_q && wr_q && wait_q != `XM_WAIT_NONE);
      end
   end

   // shared address/data bus drive
   always_ff @(posedge clk) begin
      if (rst) begin
         ad_out_q <= 8'h00;
         ad_oe_q <= 8'h00;
      end else if (!ext_bus_enable) begin
         ad_out_q <= port_a_out;
         ad_oe_q <= port_a_dir;
      end else begin
         case (state_q)
            ST_IDLE: begin
               ad_out_q <= f_addr[7:0];
               ad_oe_q <= {8{f_valid}};
            end
            ST_ADDR: begin
               ad_out_q <= wdata_q;
               ad_oe_q <= {8{wr_q}};
            end
            ST_DATA: begin
               ad_oe_q <= {8{wr_q}};
            end
            default: begin
               ad_oe_q <= 8'h00;
            end
         endcase
      end
   end

   // bus keeper level and pull-ups
   always_ff @(posedge clk) begin
      if (rst) begin
         keep_q <= 8'h00;
         ad_pu_q <= 8'h00;
      end else begin
         if (ad_oe_q != 8'h00) begin
            keep_q <= ad_out_q;
         end
         // keeper holds last driven level on released lines
         ad_pu_q <= port_a_out | ({8{bus_keeper_enable}} & keep_q & ~ad_oe_q);
      end
   end

   // upper address bus and strobe pin ownership
   always_ff @(posedge clk) begin
      if (rst) begin
         up_out_q <= 8'h00;
         up_oe_q <= 8'h00;
         ale_oe_q <= 1'b0;
         strobe_oe_q <= 1'b0;
      end else if (!ext_bus_enable) begin
         up_out_q <= port_c_out;
         up_oe_q <= port_c_dir;
         ale_oe_q <= port_e_dir[1];
         strobe_oe_q <= port_e_dir[0];
      end else begin
         if (state_q == ST_IDLE && f_valid) begin
            up_out_q <= (f_addr[15:8] & upper_keep) | (port_c_out & ~upper_keep);
         end else begin
            up_out_q <= (up_out_q & upper_keep) | (port_c_out & ~upper_keep);
         end
         up_oe_q <= upper_keep | (port_c_dir & ~upper_keep);
         ale_oe_q <= 1'b1;
         strobe_oe_q <= 1'b1;
      end
   end

   // response to the core, read data sampled at the end of the data phase
   always_ff @(posedge clk) begin
      if (rst) begin
         trail_q <= 1'b0;
         resp_valid_q <= 1'b0;
         resp_rdata_q <= 8'h00;
         resp_ext_q <= 1'b0;
      end else begin
         // synchroniser lags two cycles: wait one past trail for the last strobe level
         trail_q <= (state_q == ST_TRAIL);
         resp_valid_q <= trail_q;
         resp_ext_q <= ext_q;
         if (trail_q && ext_q && !wr_q) begin
            resp_rdata_q <= bus_sync;
         end
      end
   end
endmodule : external_memory_interface

// ==== bench/ext_mem_port_chk.sv ====
// Purpose: pin protocol checker for the memory interface
// Assumes: sees top module ports only
// Notes: bind statement at the foot
`timescale 1ns/100ps
module ext_mem_port_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic ext_bus_enable,
   input wire logic bus_keeper_enable,
   input wire logic [7:0] port_a_out,
   input wire logic [7:0] port_a_dir,
   input wire logic [7:0] port_c_dir,
   input wire logic resp_valid,
   input wire logic [7:0] muxed_addr_data_bus_oe,
   input wire logic [7:0] muxed_addr_data_bus_pullup,
   input wire logic [7:0] upper_addr_bus_oe,
   input wire logic addr_latch_out,
   input wire logic addr_latch_oe,
   input wire logic rd_n_out,
   input wire logic wr_n_out,
   input wire logic strobe_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   logic stb;
   logic [2:0] low_q;
   assign stb = !rd_n_out || !wr_n_out;
   // length of the current strobe
   always_ff @(posedge clk) begin
      if (rst || !stb) begin
         low_q <= 3'h0;
      end else if (low_q != 3'h7) begin
         low_q <= low_q + 3'h1;
      end
   end
   one_strobe_a: assert property (rd_n_out || wr_n_out)
      else $error("both strobes low");
   strobe_len_a: assert property (stb |-> low_q < 3'h3)
      else $error("strobe too long");
   addr_valid_a: assert property ($fell(rd_n_out) || $fell(wr_n_out) |->
      $fell(addr_latch_out) && $past(muxed_addr_data_bus_oe) == 8'hff)
      else $error("no address before strobe");
   latch_low_a: assert property (stb |-> !addr_latch_out)
      else $error("latch high in data phase");
   pins_owned_a: assert property (stb |-> strobe_oe && addr_latch_oe)
      else $error("strobe pin not driven");
   wr_drive_a: assert property (!wr_n_out |-> muxed_addr_data_bus_oe == 8'hff)
      else $error("write data not driven");
   rd_release_a: assert property (!rd_n_out |-> muxed_addr_data_bus_oe == 8'h00)
      else $error("bus driven during read");
   resp_after_a: assert property ($rose(rd_n_out) || $rose(wr_n_out) |-> ##[1:2] resp_valid)
      else $error("no response after strobe");
   port_mode_a: assert property (!ext_bus_enable && $past(!ext_bus_enable) && $past(!rst)
      && $stable(port_a_dir) && $stable(port_c_dir) |->
      muxed_addr_data_bus_oe == port_a_dir && upper_addr_bus_oe == port_c_dir)
      else $error("pins not in port mode");
   pullup_a: assert property (!bus_keeper_enable && $past(!bus_keeper_enable)
      && $past(!rst) && $stable(port_a_out) |-> muxed_addr_data_bus_pullup == port_a_out)
      else $error("pull-up mismatch");
endmodule : ext_mem_port_chk
bind external_memory_interface ext_mem_port_chk u_chk (.clk, .rst, .ext_bus_enable,
   .bus_keeper_enable, .port_a_out, .port_a_dir, .port_c_dir, .resp_valid,
   .muxed_addr_data_bus_oe, .muxed_addr_data_bus_pullup, .upper_addr_bus_oe,
   .addr_latch_out, .addr_latch_oe, .rd_n_out, .wr_n_out, .strobe_oe);

// ==== bench/ext_mem_port_sram_model.sv ====
// Purpose: latch plus static memory on the muxed bus
// Assumes: strobe timed, no clock
// Notes: released bus shows pull-up or inverted last level
`timescale 1ns/100ps
module ext_mem_port_sram_model #(
   parameter int ACC_NS = 3
) (
   input wire logic [7:0] muxed_addr_data_bus_out,
   input wire logic [7:0] muxed_addr_data_bus_oe,
   input wire logic [7:0] muxed_addr_data_bus_pullup,
   input wire logic [7:0] upper_addr_bus_out,
   input wire logic addr_latch_out,
   input wire logic rd_n_out,
   input wire logic wr_n_out,
   output logic [7:0] muxed_addr_data_bus_in
);
   logic [7:0] mem [0:65535];
   logic [15:0] a_q;
   logic [7:0] drv, last, wd, ad_dly;
   logic en;
   initial begin
      en = 1'b0;
      last = 8'h00;
   end
   // wire level from all drivers
   assign muxed_addr_data_bus_in = (muxed_addr_data_bus_oe & muxed_addr_data_bus_out) |
      (~muxed_addr_data_bus_oe & (en ? drv : (muxed_addr_data_bus_pullup | ~last)));
   assign #1 ad_dly = muxed_addr_data_bus_in;
   always @(muxed_addr_data_bus_in) begin
      if (en || muxed_addr_data_bus_oe == 8'hff) last = muxed_addr_data_bus_in;
   end
   always @(negedge addr_latch_out) a_q[7:0] = ad_dly;
   always @(negedge rd_n_out or negedge wr_n_out) a_q[15:8] = upper_addr_bus_out;
   always @(negedge rd_n_out) begin
      #(ACC_NS);
      drv = mem[a_q];
      en = 1'b1;
   end
   always @(posedge rd_n_out) begin
      #25;
      en = 1'b0;
   end
   always @(negedge wr_n_out) begin
      #5;
      wd = muxed_addr_data_bus_in;
   end
   always @(posedge wr_n_out) mem[a_q] = wd;
endmodule : ext_mem_port_sram_model

// ==== bench/tb.sv ====
// Purpose: self-checking bench for the memory interface
// Assumes: model memory on the bus
// Notes: table of sector and wait cases, then edge cases
`timescale 1ns/100ps
module tb;
   logic clk, rst, ext_bus_enable, bus_keeper_enable, req_valid, req_write, next_is_data;
   logic req_ready, resp_valid, resp_external, addr_latch_out, addr_latch_oe;
   logic rd_n_out, wr_n_out, strobe_oe, ale_q, ext, full;
   logic [1:0] sector_wait_code_lo, sector_wait_code_hi, port_e_out, port_e_dir;
   logic [2:0] sector_limit_field, upper_addr_mask_field;
   logic [7:0] port_a_out, port_a_dir, port_c_out, port_c_dir, req_wdata, resp_rdata;
   logic [7:0] muxed_addr_data_bus_in, muxed_addr_data_bus_out, muxed_addr_data_bus_oe;
   logic [7:0] muxed_addr_data_bus_pullup, upper_addr_bus_out, upper_addr_bus_oe;
   logic [7:0] rd, low_n, ale_n, hi_oe;
   logic [15:0] req_addr;
   int bad_count, cmp_count, cyc, resp_n, pushed, n;
   typedef struct packed {
      logic [2:0] lim;
      logic [1:0] wl, wh;
      logic [15:0] a;
      logic [7:0] d, n;
   } row_t;
   row_t rows [0:5] = '{'{3'h0, 2'h3, 2'h0, 16'h0260, 8'h5a, 8'h01},
      '{3'h1, 2'h1, 2'h2, 16'h1fff, 8'ha5, 8'h02}, '{3'h1, 2'h1, 2'h2, 16'h2000, 8'h3c, 8'h03},
      '{3'h7, 2'h3, 2'h0, 16'hdfff, 8'hc3, 8'h03}, '{3'h7, 2'h2, 2'h1, 16'he000, 8'h0f, 8'h02},
      '{3'h4, 2'h0, 2'h3, 16'h8000, 8'hf0, 8'h03}};
   external_memory_interface DUT (.*);
   ext_mem_port_sram_model mem_u (.muxed_addr_data_bus_out, .muxed_addr_data_bus_oe,
      .muxed_addr_data_bus_pullup, .upper_addr_bus_out, .addr_latch_out, .rd_n_out,
      .wr_n_out, .muxed_addr_data_bus_in);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (!rd_n_out || !wr_n_out) low_n = low_n + 8'h1;
      if (addr_latch_out && !ale_q) ale_n = ale_n + 8'h1;
      ale_q = addr_latch_out;
      if (!wr_n_out) hi_oe = upper_addr_bus_out;
      if (resp_valid) resp_n++;
      cyc++;
      if (cyc == 8000) begin
         bad_count++;
         summarize();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask : chk
   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
      low_n = 8'h0;
      ale_n = 8'h0;
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      do @(negedge clk); while (req_ready !== 1'b1);
      @(posedge clk);
      req_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (resp_valid !== 1'b1 && n < 40);
      chk({7'h0, resp_valid}, 8'h1, "no response");
      rd = resp_rdata;
      ext = resp_external;
   endtask : acc
   task automatic summarize;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize
   initial begin
      {rst, ale_q} = 2'b10;
      {ext_bus_enable, bus_keeper_enable, req_valid, req_write, next_is_data} = 5'h0;
      {sector_wait_code_lo, sector_wait_code_hi, port_e_out, port_e_dir} = 8'h04;
      {sector_limit_field, upper_addr_mask_field, req_wdata, req_addr} = 30'h0;
      {port_a_out, port_a_dir, port_c_out, port_c_dir} = 32'h960f00f0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk({4'h0, rd_n_out, wr_n_out, resp_valid, strobe_oe}, 8'h0c, "reset pins");
      ext_bus_enable <= 1'b1;
      foreach (rows[i]) begin
         @(posedge clk);
         sector_limit_field <= rows[i].lim;
         sector_wait_code_lo <= rows[i].wl;
         sector_wait_code_hi <= rows[i].wh;
         acc(1'b1, rows[i].a, rows[i].d);
         chk(low_n, rows[i].n, "write wait");
         acc(1'b0, rows[i].a, 8'h00);
         chk(rd, rows[i].d, "read back");
         chk(low_n, rows[i].n, "read wait");
         chk({7'h0, ext}, 8'h1, "not external");
      end
      $display("table done");
      acc(1'b0, 16'h025f, 8'h00);
      chk(low_n, 8'h0, "strobe on internal");
      chk({7'h0, ext}, 8'h0, "internal flagged");
      next_is_data <= 1'b1;
      acc(1'b1, 16'h3000, 8'h11);
      chk(ale_n, 8'h2, "no trailing latch");
      next_is_data <= 1'b0;
      acc(1'b1, 16'h3001, 8'h12);
      chk(ale_n, 8'h1, "extra latch pulse");
      upper_addr_mask_field <= 3'h2;
      bus_keeper_enable <= 1'b1;
      acc(1'b1, 16'hff00, 8'h22);
      chk(hi_oe, 8'h3f, "upper mask");
      chk(muxed_addr_data_bus_pullup, 8'hb6, "keeper level");
      upper_addr_mask_field <= 3'h0;
      bus_keeper_enable <= 1'b0;
      $display("edge cases done");
      ext_bus_enable <= 1'b0;
      acc(1'b1, 16'h4000, 8'h33);
      chk(low_n, 8'h0, "strobe while off");
      chk({7'h0, ext}, 8'h0, "external while off");
      repeat (3) @(negedge clk);
      chk(muxed_addr_data_bus_oe, port_a_dir, "ad dir");
      chk(upper_addr_bus_oe, port_c_dir, "upper dir");
      chk({7'h0, rd_n_out}, {7'h0, port_e_out[0]}, "rd pin port");
      chk(muxed_addr_data_bus_pullup, port_a_out, "pull-up");
      ext_bus_enable <= 1'b1;
      acc(1'b0, 16'h3000, 8'h00);
      chk(rd, 8'h11, "re-enable read");
      $display("disable done");
      {sector_wait_code_lo, sector_wait_code_hi} <= 4'hf;
      @(posedge clk);
      {req_valid, req_write, req_addr} <= {2'b11, 16'h2000};
      {full, pushed, n, resp_n} = '0;
      while (!full && n < 60) begin
         @(negedge clk);
         n++;
         if (req_ready) pushed++;
         else full = 1'b1;
      end
      @(posedge clk);
      req_valid <= 1'b0;
      n = 0;
      while (resp_n != pushed && n < 400) begin
         @(negedge clk);
         n++;
      end
      chk({7'h0, full}, 8'h1, "buffer never full");
      chk(8'(resp_n), 8'(pushed), "lost requests");
      $display("buffer done");
      summarize();
   end
endmodule : tb
